// [common/fconv_pkg.sv]
package fconv_pkg;
  // ==========================================
  // Operation codes
  localparam logic [7:0] OPC_FIX_MODE       = 8'h79; // 121
  localparam logic [7:0] OPC_FIX_MODE_FLAGS = 8'h7A; // 122
  localparam logic [7:0] OPC_FIX_TRUNC      = 8'h15; // 21
  localparam logic [7:0] OPC_FIX_TRUNC_FLAGS = 8'h81; // 129
  // ==========================================
  // Flag vector bit positions
  localparam int FLG_DIV_ZERO_POS    = 0;
  localparam int FLG_PREC_LOSS_POS   = 1;
  localparam int FLG_UNDERFLOW_POS   = 2;
  localparam int FLG_OVERFLOW_POS    = 3;
  localparam int FLG_BAD_OPERAND_POS = 4;
  localparam int FLG_IN_FLUSH_POS    = 5;
  localparam int FLG_OUT_FLUSH_POS   = 6;
  localparam int FLG_WIDTH           = 7;
  // ==========================================
  // Rounding mode encodings
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_ZERO    = 2'h1;
  localparam logic [1:0] RND_POS     = 2'h2;
  localparam logic [1:0] RND_NEG     = 2'h3;
  // ==========================================
  // Special results
  localparam logic [31:0] INT_MOST_NEG = 32'h8000_0000;
  localparam logic [31:0] INT_MOST_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] INT_ZERO     = 32'h0000_0000;
  localparam logic [FLG_WIDTH-1:0] FLAGS_NONE = 7'h00;
  // ==========================================
  // Timing and slots
  localparam int LATENCY     = 3;
  localparam int SLOT_COUNT  = 5;
  localparam logic [4:0] SLOT_ALLOWED = 5'h09; // slots 1 and 4
  // ==========================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [2:0]  slot;
    logic        guard;
    logic [31:0] source_operand;
    logic [6:0]  dest_reg;
  } issue_type;
  typedef struct packed {
    logic        wr_en;
    logic [6:0]  dest_reg;
    logic [31:0] data;
  } result_type;
endpackage

// [rtl/fconv_core.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Combinational float to int converter
module fconv_core
  import fconv_pkg::*;
(
  // Operand
  input  wire logic [31:0]          source_operand_i,
  input  wire logic [1:0]           round_mode_i,
  // Result
  output logic [31:0]               value_o,
  output logic [FLG_WIDTH-1:0]      flags_o
);
  wire        sgn  = source_operand_i[31];
  wire [7:0]  expo = source_operand_i[30:23];
  wire [22:0] frac = source_operand_i[22:0];
  wire        is_nan  = (expo == 8'hFF) && (frac != 23'h0);
  wire        is_inf  = (expo == 8'hFF) && (frac == 23'h0);
  wire        is_den  = (expo == 8'h00) && (frac != 23'h0);
  wire        is_zero = (expo == 8'h00);
  // Magnitude with 32 integer bits and 24 fraction bits
  wire [23:0] mant = {1'b1, frac};
  wire        big  = (expo >= 8'd159);
  logic [55:0] fixed;
  // Exponent 126 puts the hidden bit on the half position; below it only sticky remains
  always_comb begin
    fixed = 56'h0;
    if (!is_zero && !big && expo >= 8'd126)
      fixed = {32'h0, mant} << (expo - 8'd126);
    else if (!is_zero && !big)
      fixed = 56'h1; // tiny, sticky only
  end
  wire [31:0] ipart = fixed[55:24];
  wire        half  = fixed[23];
  wire        rest  = |fixed[22:0];
  wire        loss  = half | rest;
  logic       rup;
  always_comb begin
    unique case (round_mode_i)
      RND_NEAREST: rup = half && (rest || ipart[0]);
      RND_ZERO:    rup = 1'b0;
      RND_POS:     rup = loss && !sgn;
      RND_NEG:     rup = loss && sgn;
    endcase
  end
  wire [32:0] mag = {1'b0, ipart} + {32'h0, rup};
  wire ovf_pos = !sgn && (big || mag > {1'b0, INT_MOST_POS});
  wire ovf_neg = sgn && (big || mag > {1'b0, INT_MOST_NEG});
  always_comb begin
    value_o = INT_ZERO;
    flags_o = FLAGS_NONE;
    if (is_nan) begin
      flags_o[FLG_BAD_OPERAND_POS] = 1'b1;
    end else if (is_den) begin
      flags_o[FLG_IN_FLUSH_POS] = 1'b1;
    end else if (is_zero) begin
      value_o = INT_ZERO;
    end else if (ovf_neg || (is_inf && sgn)) begin
      value_o = INT_MOST_NEG;
      flags_o[FLG_BAD_OPERAND_POS] = 1'b1;
    end else if (ovf_pos || is_inf) begin
      value_o = INT_MOST_POS;
      flags_o[FLG_BAD_OPERAND_POS] = 1'b1;
    end else begin
      value_o = sgn ? (32'h0 - mag[31:0]) : mag[31:0];
      flags_o[FLG_PREC_LOSS_POS] = loss;
    end
  end
endmodule
`default_nettype wire

// [rtl/fconv_decode.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Operation decoder
module fconv_decode
  import fconv_pkg::*;
(
  // Issue
  input  wire logic [7:0] opcode_i,
  input  wire logic [2:0] slot_i,
  // Decoded
  output logic            hit_o,
  output logic            flags_only_o,
  output logic            trunc_o
);
  // Slot legality; other slots hold no float converter
  wire slot_ok = (slot_i >= 3'd1) && (slot_i <= 3'd5) &&
                 SLOT_ALLOWED[3'(slot_i - 3'd1)];
  wire is_op   = (opcode_i == OPC_FIX_MODE) || (opcode_i == OPC_FIX_MODE_FLAGS) ||
                 (opcode_i == OPC_FIX_TRUNC) || (opcode_i == OPC_FIX_TRUNC_FLAGS);
  assign hit_o        = is_op && slot_ok;
  assign flags_only_o = (opcode_i == OPC_FIX_MODE_FLAGS) || (opcode_i == OPC_FIX_TRUNC_FLAGS);
  assign trunc_o      = (opcode_i == OPC_FIX_TRUNC) || (opcode_i == OPC_FIX_TRUNC_FLAGS);
endmodule
`default_nettype wire

// [rtl/fconv_unit.sv]
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - The truncating conversion rounds toward zero whatever the status rounding mode.
// - The mode-rounded flag-only operation rounds with the status rounding mode.
// - A denormal source of a conversion converts as zero and sets input-flushed.
// - A denormal source of a flag-only op returns the input-flushed bit 0x20.
// - Status flags are sticky; only an explicit status write clears them.
// - Status flag updates leave in the same cycle as the destination write.
// - Concurrent flag updates OR with each other and the held value.
// - A false guard suppresses both destination and flag writes.
// - Flag-only ops write the flag vector and leave status flags alone.
// - Flag bits: div-zero 0, inexact 1, under 2, over 3, invalid 4, flushes 5 and 6.
// - Negative overflow returns 0x80000000 with invalid.
// - Positive infinity returns 0x7fffffff with invalid.
// - Not-a-number returns zero with invalid.
// - Opcodes: 122 mode flags, 21 truncate, 129 truncate flags.
// - Latency 3, issue only from slots 1 and 4.
// - Mode-rounded conversion uses the status rounding mode with flush.
module fconv_unit
  import fconv_pkg::*;
#(
  parameter int LAT = LATENCY
)
(
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  reset_n_i,
  // Issue
  input  wire fconv_pkg::issue_type  issue_i,
  // Status word
  input  wire logic [1:0]            round_mode_i,
  input  wire logic [FLG_WIDTH-1:0]  status_flags_i,
  input  wire logic                  other_set_valid_i,
  input  wire logic [FLG_WIDTH-1:0]  other_set_flags_i,
  input  wire logic                  status_write_i,
  input  wire logic [FLG_WIDTH-1:0]  status_write_data_i,
  // Results
  output var fconv_pkg::result_type  result_o,
  output logic                       flag_set_valid_o,
  output logic [FLG_WIDTH-1:0]       flag_set_o,
  output logic [FLG_WIDTH-1:0]       status_flags_o
);
  // ==========================================
  // Elaboration checks
  if (LAT != LATENCY) begin : g_bad_lat
    $error("latency must be 3");
  end

  // ==========================================
  // Decode
  logic hit;
  logic flags_only;
  logic trunc;
  fconv_decode u_dec (
    .opcode_i     (issue_i.opcode),
    .slot_i       (issue_i.slot),
    .hit_o        (hit),
    .flags_only_o (flags_only),
    .trunc_o      (trunc)
  );

  wire [1:0] eff_mode = trunc ? RND_ZERO : round_mode_i;

  // ==========================================
  // Stage 1: capture
  logic                 s1_valid_ff;
  logic                 s1_fonly_ff;
  logic [6:0]           s1_dest_ff;
  logic [31:0]          s1_src_ff;
  logic [1:0]           s1_mode_ff;
  wire nxt_s1_valid = issue_i.valid && hit && issue_i.guard;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s1_valid_ff <= 1'b0;
      s1_fonly_ff <= 1'b0;
      s1_dest_ff  <= 7'h00;
      s1_src_ff   <= 32'h0000_0000;
      s1_mode_ff  <= 2'h0;
    end else begin
      s1_valid_ff <= nxt_s1_valid;
      s1_fonly_ff <= flags_only;
      s1_dest_ff  <= issue_i.dest_reg;
      s1_src_ff   <= issue_i.source_operand;
      s1_mode_ff  <= eff_mode;
    end
  end

  // ==========================================
  // Stage 2: compute
  logic [31:0]          conv_val;
  logic [FLG_WIDTH-1:0] conv_flg;
  fconv_core u_core (
    .source_operand_i (s1_src_ff),
    .round_mode_i     (s1_mode_ff),
    .value_o          (conv_val),
    .flags_o          (conv_flg)
  );

  logic                 s2_valid_ff;
  logic                 s2_fonly_ff;
  logic [6:0]           s2_dest_ff;
  logic [31:0]          s2_val_ff;
  logic [FLG_WIDTH-1:0] s2_flg_ff;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s2_valid_ff <= 1'b0;
      s2_fonly_ff <= 1'b0;
      s2_dest_ff  <= 7'h00;
      s2_val_ff   <= 32'h0000_0000;
      s2_flg_ff   <= FLAGS_NONE;
    end else begin
      s2_valid_ff <= s1_valid_ff;
      s2_fonly_ff <= s1_fonly_ff;
      s2_dest_ff  <= s1_dest_ff;
      s2_val_ff   <= conv_val;
      s2_flg_ff   <= conv_flg;
    end
  end

  // ==========================================
  // Stage 3: writeback, third edge after issue
  // flag vector as data
  wire [31:0] nxt_data = s2_fonly_ff ? {25'h0, s2_flg_ff} : s2_val_ff;
  wire nxt_set_valid = s2_valid_ff && !s2_fonly_ff;
  // sticky OR merge, set beats write
  wire [FLG_WIDTH-1:0] nxt_own = nxt_set_valid ? s2_flg_ff : FLAGS_NONE;
  wire [FLG_WIDTH-1:0] other   = other_set_valid_i ? other_set_flags_i : FLAGS_NONE;
  wire [FLG_WIDTH-1:0] base    = status_write_i ? status_write_data_i : status_flags_i;
  wire [FLG_WIDTH-1:0] nxt_status = base | nxt_own | other;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      result_o         <= '0;
      flag_set_valid_o <= 1'b0;
      flag_set_o       <= FLAGS_NONE;
      status_flags_o   <= FLAGS_NONE;
    end else begin
      result_o.wr_en   <= s2_valid_ff;
      result_o.dest_reg <= s2_dest_ff;
      result_o.data    <= nxt_data;
      flag_set_valid_o <= nxt_set_valid;
      flag_set_o       <= nxt_own;
      // merged view for the status word
      status_flags_o   <= nxt_status;
    end
  end
endmodule
`default_nettype wire

// [tb/fconv_status_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Status word holder on the issue side
module fconv_status_model
  import fconv_pkg::*;
(
  // Reset
  input  wire logic                 reset_n_i,
  // Merged flags from the unit
  input  wire logic [FLG_WIDTH-1:0] merged_i,
  output logic [FLG_WIDTH-1:0]      status_word_o
);
  // merged word fed back
  // The unit already registers the merge; a second register would drop sticky bits
  assign status_word_o = reset_n_i ? merged_i : FLAGS_NONE;
endmodule
`default_nettype wire

// [tb/fconv_unit_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checker for the converter
module fconv_unit_props
  import fconv_pkg::*;
#(parameter int LAT = LATENCY)
(
  input wire logic                 mclk_i,
  input wire logic                 reset_n_i,
  input wire fconv_pkg::issue_type issue_i,
  input wire logic [FLG_WIDTH-1:0] status_flags_i,
  input wire logic                 other_set_valid_i,
  input wire logic [FLG_WIDTH-1:0] other_set_flags_i,
  input wire logic                 status_write_i,
  input wire fconv_pkg::result_type result_o,
  input wire logic                 flag_set_valid_o,
  input wire logic [FLG_WIDTH-1:0] flag_set_o,
  input wire logic [FLG_WIDTH-1:0] status_flags_o
);
  // Decode of an accepted issue
  wire logic [7:0]  opc  = issue_i.opcode;
  wire logic [31:0] src  = issue_i.source_operand;
  wire logic        conv = opc == OPC_FIX_MODE || opc == OPC_FIX_TRUNC;
  wire logic        take = issue_i.valid && issue_i.guard && issue_i.slot inside {3'h1, 3'h4}
    && (conv || opc == OPC_FIX_MODE_FLAGS || opc == OPC_FIX_TRUNC_FLAGS);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_done; ##3 result_o.wr_en; endsequence
  property p_lat; take |-> s_done; endproperty
  a_lat: assert property (p_lat) else $error("missing write after issue");
  property p_wr; result_o.wr_en |-> $past(take, 3); endproperty
  a_wr: assert property (p_wr) else $error("write without accepted issue");
  property p_fonly; result_o.wr_en && !$past(conv, 3) |->
    !flag_set_valid_o && result_o.data[31:7] == 25'h0; endproperty
  a_fonly: assert property (p_fonly) else $error("flag op result wrong");
  property p_setwr; flag_set_valid_o |-> result_o.wr_en; endproperty
  a_setwr: assert property (p_setwr) else $error("flag set without write");
  property p_keep; $past(reset_n_i) && !$past(status_write_i) |->
    (status_flags_o & $past(status_flags_i)) == $past(status_flags_i); endproperty
  a_keep: assert property (p_keep) else $error("status flag lost");
  property p_other; $past(reset_n_i) && $past(other_set_valid_i) |->
    (status_flags_o & $past(other_set_flags_i)) == $past(other_set_flags_i); endproperty
  a_other: assert property (p_other) else $error("other set lost");
  property p_own; flag_set_valid_o |-> (status_flags_o & flag_set_o) == flag_set_o; endproperty
  a_own: assert property (p_own) else $error("own set lost");
  property p_nan; take && conv && src[30:23] == 8'hFF && src[22:0] != 23'h0 |->
    ##3 result_o.data == INT_ZERO && flag_set_o[FLG_BAD_OPERAND_POS]; endproperty
  a_nan: assert property (p_nan) else $error("nan result wrong");
  property p_dnz; take && !conv && src[30:23] == 8'h00 && src[22:0] != 23'h0 |->
    ##3 result_o.data == 32'h0000_0020; endproperty
  a_dnz: assert property (p_dnz) else $error("denormal flags wrong");
  property p_negbig; take && conv && src[31] && src[30:23] >= 8'd159 && src[30:23] != 8'hFF
    |-> ##3 result_o.data == INT_MOST_NEG && flag_set_o[FLG_BAD_OPERAND_POS]; endproperty
  a_negbig: assert property (p_negbig) else $error("negative overflow wrong");
  property p_inf; take && conv && src == 32'h7F80_0000 |->
    ##3 result_o.data == INT_MOST_POS && flag_set_o[FLG_BAD_OPERAND_POS]; endproperty
  a_inf: assert property (p_inf) else $error("infinity result wrong");
endmodule
bind fconv_unit fconv_unit_props #(.LAT(LAT)) fconv_unit_props_inst (.mclk_i(mclk_i),
  .reset_n_i(reset_n_i), .issue_i(issue_i), .status_flags_i(status_flags_i),
  .other_set_valid_i(other_set_valid_i), .other_set_flags_i(other_set_flags_i),
  .status_write_i(status_write_i), .result_o(result_o), .flag_set_valid_o(flag_set_valid_o),
  .flag_set_o(flag_set_o), .status_flags_o(status_flags_o));
`default_nettype wire

// [tb/fconv_unit_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t got %h expected %h", $time, g, e); end end
module fconv_unit_tb;
  import fconv_pkg::*;
  typedef struct packed {logic [6:0] dest; logic [31:0] data; logic sv; logic [6:0] f;} note_type;
  logic mclk_i = 0, reset_n_i = 0, other_v = 0, wr = 0;
  issue_type   issue_i = '0;
  logic [1:0]  rm = 2'h0;
  logic [6:0]  other_f = 7'h0;
  logic [6:0]  wd = 7'h0;
  logic [15:0] lfsr = 16'h0002;
  int          bad_count = 0, comparisons = 0, cycles = 0;
  note_type    q[$], n;
  result_type  result_o;
  wire logic   setv;
  wire logic [6:0] setf, sflags, sword;
  logic [31:0] src_t [8] = '{32'h4040_0000, 32'h4024_7AE1, 32'hFF4F_FFFF, 32'h7F80_0000,
    32'hBFC1_47AE, 32'h0040_0000, 32'hFFFF_FFFF, 32'hFFBF_FFFF};
  logic [31:0] trz_t [8] = '{3, 2, INT_MOST_NEG, INT_MOST_POS, 32'hFFFF_FFFF, 0, 0, 0};
  logic [31:0] rne_t [8] = '{3, 3, INT_MOST_NEG, INT_MOST_POS, 32'hFFFF_FFFE, 0, 0, 0};
  logic [6:0]  flg_t [8] = '{7'h00, 7'h02, 7'h10, 7'h10, 7'h02, 7'h20, 7'h10, 7'h10};
  always #2 mclk_i = ~mclk_i;
  fconv_unit #(.LAT(LATENCY)) fconv_unit_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .issue_i(issue_i), .round_mode_i(rm), .status_flags_i(sword), .other_set_valid_i(other_v),
    .other_set_flags_i(other_f), .status_write_i(wr), .status_write_data_i(wd),
    .result_o(result_o), .flag_set_valid_o(setv), .flag_set_o(setf), .status_flags_o(sflags));
  fconv_status_model fconv_status_model_inst (.reset_n_i(reset_n_i), .merged_i(sflags),
    .status_word_o(sword));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task wrap_up;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One issue per cycle; slot 0 means a legal random slot
  task automatic send(input logic [7:0] op, input logic [31:0] s, input logic [1:0] r,
      input logic g, input logic [2:0] sl, input logic [31:0] v, input logic [6:0] f);
    logic c;
    c = op == OPC_FIX_MODE || op == OPC_FIX_TRUNC;
    @(posedge mclk_i);
    lfsr = lfsr_next(lfsr);
    issue_i <= '{1'b1, op, sl != 0 ? sl : (lfsr[0] ? 3'h1 : 3'h4), g, s, lfsr[7:1]};
    rm <= r;
    other_v <= lfsr[8];
    other_f <= lfsr[15:9];
    wr <= lfsr[12:9] == 4'h0; // Rare clears keep sticky flags visible
    wd <= lfsr[14:8];
    if (g && sl != 3'h2 && op inside {OPC_FIX_MODE, OPC_FIX_MODE_FLAGS, OPC_FIX_TRUNC,
        OPC_FIX_TRUNC_FLAGS}) q.push_back('{lfsr[7:1], c ? v : {25'h0, f}, c, c ? f : 7'h0});
  endtask
  // Results compared against the oldest note; a hang ends in the same report
  always @(negedge mclk_i) begin
    cycles++;
    if (cycles == 600) begin
      bad_count++;
      wrap_up();
    end else if (reset_n_i && result_o.wr_en !== 1'b0) begin
      if (q.size() == 0) `CHK(result_o.wr_en, 1'b0)
      else begin
        n = q.pop_front();
        `CHK(result_o.dest_reg, n.dest)
        `CHK(result_o.data, n.data)
        `CHK(setv, n.sv)
        `CHK(setf & {7{n.sv}}, n.f)
        `CHK(sflags & n.f, n.f)
      end
    end
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      send(OPC_FIX_TRUNC, src_t[i], lfsr[1:0], 1, 0, trz_t[i], flg_t[i]);
      send(OPC_FIX_TRUNC_FLAGS, src_t[i], lfsr[3:2], 1, 0, 0, flg_t[i]);
      send(OPC_FIX_MODE, src_t[i], RND_NEAREST, 1, 0, rne_t[i], flg_t[i]);
      send(OPC_FIX_MODE_FLAGS, src_t[i], RND_NEAREST, 1, 0, 0, flg_t[i]);
      send(OPC_FIX_TRUNC, src_t[i], 0, 0, 0, 0, 0);
      send(OPC_FIX_MODE, src_t[i], 0, 1, 3'h2, 0, 0);
      send(8'h14, src_t[i], 0, 1, 0, 0, 0);
    end
    // Directed modes on 2.57 and -1.51, plus the exact most negative integer
    send(OPC_FIX_MODE, 32'h4024_7AE1, RND_ZERO, 1, 0, 32'h0000_0002, 7'h02);
    send(OPC_FIX_MODE, 32'h4024_7AE1, RND_POS, 1, 0, 32'h0000_0003, 7'h02);
    send(OPC_FIX_MODE, 32'h4024_7AE1, RND_NEG, 1, 0, 32'h0000_0002, 7'h02);
    send(OPC_FIX_MODE, 32'hBFC1_47AE, RND_POS, 1, 0, 32'hFFFF_FFFF, 7'h02);
    send(OPC_FIX_MODE, 32'hBFC1_47AE, RND_NEG, 1, 0, 32'hFFFF_FFFE, 7'h02);
    send(OPC_FIX_MODE_FLAGS, 32'h4024_7AE1, RND_POS, 1, 0, 0, 7'h02);
    send(OPC_FIX_TRUNC, 32'hCF00_0000, RND_NEAREST, 1, 0, INT_MOST_NEG, 7'h00);
    @(posedge mclk_i);
    issue_i.valid <= 1'b0;
    repeat (8) @(posedge mclk_i);
    `CHK(q.size(), 0)
    wrap_up();
  end
endmodule
`default_nettype wire
